// *** rtl/sfcs_pkg.sv ***
// Constants and types for the flash command-triplet sequencer
package sfcs_pkg;
  localparam int ROW_W  = 12;
  localparam int COL_W  = 9;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REQ_W  = BANK_W + ROW_W + COL_W;
  localparam logic [7:0] PROG_SETUP_CODE  = 8'h40;
  localparam logic [7:0] READ_STATUS_CODE = 8'h70;
  localparam logic [2:0] CASLAT_RESET = 3'h2;
  localparam logic [2:0] RCD_CYCLES   = 3'h1;
  localparam int STATUS_W = 8;

  // Command encodings as {csN, rasN, casN, weN}
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_LCR   = 4'h0;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_DESEL = 4'hF;

  typedef enum logic [2:0] {
    S_IDLE, S_LCR, S_ACT, S_LAST, S_WAIT, S_DONE
  } sfcs_state_e;

  typedef struct packed {
    logic [3:0]        cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } sfcs_cmd_s;
endpackage

// *** rtl/sfcs_sequencer.sv ***
// Flash command-triplet sequencer for program and status read
`timescale 1ns/1ps
module sfcs_sequencer
  import sfcs_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // Requester side
  input  wire logic              reqValid,
  input  wire logic              reqWrite,
  input  wire logic [REQ_W-1:0]  reqAddr,
  input  wire logic [DATA_W-1:0] reqWdata,
  input  wire logic [2:0]        cas_latency_cycles,
  output logic                   reqReady,
  output logic                   rspValid,
  output logic [DATA_W-1:0]      rspRdata,
  // Flash side
  output sfcs_cmd_s              memCmd,
  output logic [DATA_W-1:0]      memDqOut,
  output logic                   memDqOe,
  input  wire logic [DATA_W-1:0] memDqIn
);
  // ************************************************************
  // Sequencer state
  // ************************************************************
  sfcs_state_e       state, next_state;
  logic              isWrite, next_isWrite;
  logic [REQ_W-1:0]  addr, next_addr;
  logic [DATA_W-1:0] wdata, next_wdata;
  logic [2:0]        waitCnt, next_waitCnt;
  sfcs_cmd_s         next_memCmd;
  logic [DATA_W-1:0] next_memDqOut, next_rspRdata;
  logic              next_memDqOe, next_rspValid;
  logic [BANK_W-1:0] bank;
  logic [ROW_W-1:0]  row;
  logic [COL_W-1:0]  col;

  assign bank = addr[REQ_W-1 -: BANK_W];
  assign row  = addr[COL_W +: ROW_W];
  assign col  = addr[COL_W-1:0];
  // Accepting only in idle keeps one sequence in flight at a time
  // busy until done
  assign reqReady = (state == S_IDLE);

  always_comb begin
    next_state    = state;
    next_isWrite  = isWrite;
    next_addr     = addr;
    next_wdata    = wdata;
    next_waitCnt  = waitCnt;
    next_memCmd   = '{cmd: CMD_NOP, bank: '0, addr: '0};
    next_memDqOut = '0;
    next_memDqOe  = 1'b0;
    next_rspValid = 1'b0;
    next_rspRdata = rspRdata;
    case (state)
      S_IDLE: begin
        if (reqValid) begin
          next_isWrite = reqWrite;
          next_addr    = reqAddr;
          next_wdata   = reqWdata;
          next_state   = S_LCR;
        end
      end
      S_LCR: begin
        next_memCmd.cmd  = CMD_LCR;
        next_memCmd.bank = bank;
        next_memCmd.addr = {row[ADDR_W-1:8],
                            isWrite ? PROG_SETUP_CODE : READ_STATUS_CODE};
        next_state = S_ACT;
      end
      S_ACT: begin
        next_memCmd.cmd  = CMD_ACT;
        next_memCmd.bank = bank;
        next_memCmd.addr = row;
        next_state = S_LAST;
      end
      S_LAST: begin
        next_memCmd.bank = bank;
        next_memCmd.addr = {{(ADDR_W-COL_W){1'b0}}, col};
        if (isWrite) begin
          next_memCmd.cmd = CMD_WRITE;
          next_memDqOut   = wdata;
          next_memDqOe    = 1'b1;
          next_state = S_DONE;
        end else begin
          next_memCmd.cmd = CMD_READ;
          // Zero latency is taken as one
          next_waitCnt    = (cas_latency_cycles == 3'h0) ?
                            3'h1 : cas_latency_cycles;
          next_state      = S_WAIT;
        end
      end
      S_WAIT: begin
        // status arrives after the latency
        // The flash latches the read one edge after it leaves here,
        // so the count runs down to zero, not to one
        if (waitCnt == 3'h0) begin
          next_rspRdata = {{(DATA_W-STATUS_W){1'b0}},
                           memDqIn[STATUS_W-1:0]};
          next_state    = S_DONE;
        end else begin
          next_waitCnt = waitCnt - 3'h1;
        end
      end
      S_DONE: begin
        next_rspValid = 1'b1;
        next_state    = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state    <= S_IDLE;
      isWrite  <= 1'b0;
      addr     <= '0;
      wdata    <= '0;
      waitCnt  <= '0;
      memCmd   <= '{cmd: CMD_NOP, bank: '0, addr: '0};
      memDqOut <= '0;
      memDqOe  <= 1'b0;
      rspValid <= 1'b0;
      rspRdata <= '0;
    end else begin
      state    <= next_state;
      isWrite  <= next_isWrite;
      addr     <= next_addr;
      wdata    <= next_wdata;
      waitCnt  <= next_waitCnt;
      memCmd   <= next_memCmd;
      memDqOut <= next_memDqOut;
      memDqOe  <= next_memDqOe;
      rspValid <= next_rspValid;
      rspRdata <= next_rspRdata;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  // One clock for every check; all are off while reset stands
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_prog_setup: assert property (
    memCmd.cmd == CMD_LCR && isWrite |->
      memCmd.addr[7:0] == PROG_SETUP_CODE)
    else $error("program setup code wrong");
  a_stat_setup: assert property (
    memCmd.cmd == CMD_LCR && !isWrite |->
      memCmd.addr[7:0] == READ_STATUS_CODE)
    else $error("status setup code wrong");
  a_lcr_bank: assert property (
    memCmd.cmd == CMD_LCR |->
      memCmd.bank == bank)
    else $error("setup bank wrong");
  a_lcr_upper: assert property (
    memCmd.cmd == CMD_LCR |->
      memCmd.addr[ADDR_W-1:8] == row[ADDR_W-1:8])
    else $error("setup upper address wrong");
  a_prog_act: assert property (
    memCmd.cmd == CMD_LCR && isWrite |=> memCmd.cmd == CMD_ACT
      && memCmd.addr == row && memCmd.bank == bank)
    else $error("program activate missing");
  a_prog_wr: assert property (
    memCmd.cmd == CMD_ACT && isWrite |=> memCmd.cmd == CMD_WRITE
      && memDqOe && memDqOut == wdata)
    else $error("program write wrong");
  a_wr_col: assert property (
    memCmd.cmd == CMD_WRITE |-> memCmd.bank == bank
      && memCmd.addr[COL_W-1:0] == col
      && memCmd.addr[ADDR_W-1:COL_W] == '0)
    else $error("program column wrong");
  // Data is driven with the write command only
  a_dq_write: assert property (
    memDqOe |->
      memCmd.cmd == CMD_WRITE)
    else $error("data driven outside write");
  a_no_term: assert property (
    memCmd.cmd == CMD_WRITE |=> memCmd.cmd == CMD_NOP && rspValid
      ##1 memCmd.cmd == CMD_NOP)
    else $error("extra command after write");
  a_stat_act: assert property (
    memCmd.cmd == CMD_LCR && !isWrite |=> memCmd.cmd == CMD_ACT
      && memCmd.addr == row && memCmd.bank == bank)
    else $error("status activate missing");
  a_stat_rd: assert property (
    memCmd.cmd == CMD_ACT && !isWrite |=> memCmd.cmd == CMD_READ
      && memCmd.addr[COL_W-1:0] == col && memCmd.bank == bank
      && !memDqOe)
    else $error("status read wrong");
  a_high_zero: assert property (
    rspValid |->
      rspRdata[DATA_W-1:STATUS_W] == '0)
    else $error("upper status bits not zero");
  a_held_off: assert property (
    memCmd.cmd == CMD_LCR |->
      !reqReady ##1 !reqReady ##1 !reqReady)
    else $error("requester not held");
  // Ready may only come back once the answer is out
  a_resp_after: assert property (
    rspValid |->
      !$past(reqReady))
    else $error("ready before sequence end");

  // ************************************************************
  // Scenarios worth seeing
  // ************************************************************
  c_program:   cover property (memCmd.cmd == CMD_WRITE);
  c_status:    cover property (memCmd.cmd == CMD_READ);
  c_resp:      cover property (rspValid && !isWrite);
  c_prog_resp: cover property (rspValid && isWrite);
  c_lat_zero:  cover property (memCmd.cmd == CMD_READ
                                && cas_latency_cycles == 3'h0);
endmodule

// *** tb/sfcs_flash_model.sv ***
// Flash partner model answering status reads
`timescale 1ns/1ps
module sfcs_flash_model
  import sfcs_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // Command side
  input  wire sfcs_cmd_s         memCmd,
  input  wire logic [2:0]        casLat,
  input  wire logic [7:0]        statusByte,
  // Data back
  output logic [DATA_W-1:0]      memDqIn
);
  logic [2:0]        cnt;
  logic [DATA_W-1:0] junk;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt <= 3'h0;
      junk <= 32'hA5A5_5A5A;
    end else begin
      junk <= ~junk + 32'h1;
      if (memCmd.cmd == CMD_READ) begin
        cnt <= (casLat == 3'h0) ? 3'h1 : casLat;
      end else if (cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end
    end
  end
  // Undriven bus changes every cycle so a stale capture shows
  assign memDqIn = (cnt == 3'h1) ? {junk[31:8], statusByte} : junk;
endmodule

// *** tb/sfcs_sequencer_tb.sv ***
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module sfcs_sequencer_tb
  import sfcs_pkg::*;
;
  logic              core_clk;
  logic              reset;
  logic              reqValid;
  logic              reqWrite;
  logic [REQ_W-1:0]  reqAddr;
  logic [DATA_W-1:0] reqWdata;
  logic [2:0]        casLat;
  logic [7:0]        statusByte;
  logic              reqReady;
  logic              rspValid;
  logic [DATA_W-1:0] rspRdata;
  sfcs_cmd_s         memCmd;
  logic [DATA_W-1:0] memDqOut;
  logic              memDqOe;
  logic [DATA_W-1:0] memDqIn;
  int                n_errors = 0;
  int                comparisons = 0;

  sfcs_sequencer i_sfcs_sequencer (.core_clk(core_clk), .reset(reset),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqWdata(reqWdata), .cas_latency_cycles(casLat),
    .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata),
    .memCmd(memCmd), .memDqOut(memDqOut), .memDqOe(memDqOe),
    .memDqIn(memDqIn));
  sfcs_flash_model i_sfcs_flash_model (.core_clk(core_clk), .reset(reset),
    .memCmd(memCmd), .casLat(casLat), .statusByte(statusByte),
    .memDqIn(memDqIn));

  task automatic end_of_test();
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One sequence, watched command by command until the answer
  task automatic run(input logic w, input logic [REQ_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    sfcs_cmd_s exp [3];
    int        k;
    int        n;
    int        lat;
    k = 0;
    exp[0] = '{CMD_LCR, a[22:21],
               {a[20:17], w ? PROG_SETUP_CODE : READ_STATUS_CODE}};
    exp[1] = '{CMD_ACT, a[22:21], a[20:9]};
    exp[2] = '{w ? CMD_WRITE : CMD_READ, a[22:21], {3'h0, a[8:0]}};
    @(posedge core_clk);
    lat = (casLat == 3'h0) ? 1 : int'(casLat);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr <= a;
    reqWdata <= d;
    @(posedge core_clk);
    reqValid <= 1'b0;
    for (n = 0; n < 20 && rspValid !== 1'b1; n++) begin
      @(negedge core_clk);
      if (memCmd.cmd !== CMD_NOP && k < 3) begin
        `CHK(memCmd, exp[k])
        if (k == 2 && w) `CHK(memDqOe, 1'b1)
        if (k == 2 && w) `CHK(memDqOut, d)
        if (k == 2 && !w) `CHK(memDqOe, 1'b0)
        k++;
      end else if (memCmd.cmd !== CMD_NOP) begin
        `CHK(memCmd.cmd, CMD_NOP)
      end
      if (rspValid !== 1'b1) `CHK(reqReady, 1'b0)
    end
    `CHK(k, 3)
    `CHK(n, w ? 5 : 6 + lat)
    if (!w) `CHK(rspRdata, 32'(statusByte))
    @(negedge core_clk);
    `CHK(rspValid, 1'b0)
  endtask

  // Program at the top address with all bits set, then at a mixed address and data
  task automatic t_program();
    run(1'b1, 23'h7FFFFF, 32'hFFFF_FFFF);
    run(1'b1, 23'h2A5155, 32'h1234_5678);
  endtask

  // Status read at latencies zero to three, zero treated as one
  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      casLat <= 3'(i);
      statusByte <= 8'h81 ^ 8'(i << 4);
      run(1'b0, 23'h5AEAAA ^ 23'(i), 32'h0);
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end

  initial begin
    reset = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = '0;
    reqWdata = '0;
    casLat = 3'h2;
    statusByte = 8'h80;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    t_program();
    t_status();
    end_of_test();
  end
endmodule
